// ==== sim/slgs_ref_source.sv ====
// Partner model: square-wave source for the reference or tach pin.
// Assumes the bench sets the half period in pclk cycles; 0 stops it.
`timescale 1ns/1ps
`default_nettype none
module slgs_ref_source (
   // Clock
   input  wire logic        pclk,
   // Control and pin
   input  wire logic [15:0] half,
   output logic             wave = 1'b1
);
   logic [15:0] cnt = 16'h0000;
   // period set by bench; stopped pin rests high on its pull-up
   always @(posedge pclk) begin
      if (half == 16'h0000) begin
         wave <= 1'b1;
         cnt  <= 16'h0000;
      end else if (cnt >= half - 16'h0001) begin
         wave <= ~wave;
         cnt  <= 16'h0000;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule : slgs_ref_source
`default_nettype wire

// ==== sim/slgs_speed_gate_bench.sv ====
// Self-checking bench for the speed-loop and gate-state block.
// Assumes zero-wait APB and pin effects within six edges.
`timescale 1ns/1ps
`default_nettype none
module slgs_speed_gate_bench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, start_pin = 1'b1, brake_n_pin = 1'b1;
   logic pump_rail_uv = 1'b0, reg_rail_uv = 1'b0, supply_uv = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, fref_pin, tach_feedback, err_pulldown;
   logic ref_clk_stop, ovf_flag;
   logic [2:0] pwm_upper = 3'h7, pwm_lower = 3'h0, freq_gain;
   logic [15:0] ref_half = 16'h0, tach_half = 16'h0;
   slgs_pkg::slgs_gate_s [2:0] gate_upper, gate_lower;
   slgs_pkg::slgs_cmd_e freq_cmd, phase_cmd;
   int mismatches = 0, n_compared = 0, n;
   always #12.5 pclk = ~pclk;
   slgs_ref_source u_ref (.pclk(pclk), .half(ref_half), .wave(fref_pin));
   slgs_ref_source u_tach (.pclk(pclk), .half(tach_half),
      .wave(tach_feedback));
   slgs_speed_gate #(.N_PH(3)) DUT (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .start_pin(start_pin), .brake_n_pin(brake_n_pin),
      .fref_pin(fref_pin), .tach_feedback(tach_feedback),
      .pump_rail_uv(pump_rail_uv), .reg_rail_uv(reg_rail_uv),
      .supply_uv(supply_uv), .pwm_upper(pwm_upper),
      .pwm_lower(pwm_lower), .gate_upper(gate_upper),
      .gate_lower(gate_lower), .freq_cmd(freq_cmd),
      .freq_gain(freq_gain), .phase_cmd(phase_cmd),
      .err_pulldown(err_pulldown), .ref_clk_stop(ref_clk_stop),
      .ovf_flag(ovf_flag));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task summarize;
      if (mismatches == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         mismatches++;
         summarize();
      end
   endtask : apb
   task gates(input logic [5:0] up, input logic [5:0] lo);
      chk("gate_upper", {26'h0, gate_upper}, {26'h0, up});
      chk("gate_lower", {26'h0, gate_lower}, {26'h0, lo});
   endtask : gates
   // ---------------------------------------------------------------
   // Sequence: high 2a, low 15, off 00 on all three phases
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      gates(6'h00, 6'h15);
      chk("pulldown", err_pulldown, 1'b1);
      chk("clk_stop", ref_clk_stop, 1'b1);
      apb(1'b0, slgs_pkg::OFF_CTRL, 32'h0);
      chk("ctrl", q, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("slverr", pslverr, 1'b1);
      start_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      gates(6'h2a, 6'h15);
      chk("pulldown", err_pulldown, 1'b0);
      chk("freq_cmd", freq_cmd, slgs_pkg::CMD_ACCEL);
      chk("freq_gain", freq_gain, 3'h0);
      apb(1'b1, slgs_pkg::OFF_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      gates(6'h15, 6'h15);
      apb(1'b1, slgs_pkg::OFF_CTRL, 32'h0);
      ref_half <= 16'd500;
      tach_half <= 16'd600;
      repeat (6000) @(posedge pclk);
      apb(1'b0, slgs_pkg::OFF_REFPER, 32'h0);
      chk("refper", q[15:0], 16'd1000);
      chk("freq_gain", freq_gain, 3'h7);
      chk("freq_cmd", freq_cmd, slgs_pkg::CMD_ACCEL);
      tach_half <= 16'd400;
      repeat (4000) @(posedge pclk);
      chk("freq_cmd", freq_cmd, slgs_pkg::CMD_SLOW);
      chk("phase_cmd", phase_cmd, slgs_pkg::CMD_IDLE);
      // Restart both waves with a fixed offset so the loop locks
      ref_half <= 16'h0;
      tach_half <= 16'h0;
      repeat (3) @(posedge pclk);
      ref_half <= 16'd500;
      repeat (10) @(posedge pclk);
      tach_half <= 16'd500;
      repeat (4000) @(posedge pclk);
      chk("freq_cmd", freq_cmd, slgs_pkg::CMD_IDLE);
      for (n = 0; n < 1100 && phase_cmd === slgs_pkg::CMD_IDLE; n++)
         @(posedge pclk);
      chk("phase_act", phase_cmd !== slgs_pkg::CMD_IDLE, 1'b1);
      brake_n_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      gates(6'h15, 6'h2a);
      brake_n_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      chk("freq_gain", freq_gain, 3'h0);
      pump_rail_uv <= 1'b1;
      repeat (6) @(posedge pclk);
      gates(6'h15, 6'h15);
      pump_rail_uv <= 1'b0;
      repeat (6) @(posedge pclk);
      start_pin <= 1'b1;
      for (n = 0; n < 20 && gate_upper !== 6'h15; n++) @(posedge pclk);
      if (n == 20) begin
         mismatches++;
         summarize();
      end
      for (n = 0; n < 100 && gate_upper === 6'h15; n++) @(posedge pclk);
      chk("low_cycles", n, 34);
      gates(6'h00, 6'h15);
      chk("clk_stop", ref_clk_stop, 1'b1);
      ref_half <= 16'h0;
      start_pin <= 1'b0;
      repeat (33000) @(posedge pclk);
      chk("ovf", ovf_flag, 1'b1);
      gates(6'h15, 6'h15);
      brake_n_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      brake_n_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      chk("ovf", ovf_flag, 1'b0);
      summarize();
   end
endmodule : slgs_speed_gate_bench
`default_nettype wire

// ==== src/slgs_period_meter.sv ====
// Period meter: synchronises one pin and counts clocks between rises.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module slgs_period_meter #(
   parameter int               CNT_W = slgs_pkg::CNT_W,
   parameter logic [CNT_W-1:0] LIMIT = slgs_pkg::OVF_COUNT
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Control and pin
   input  wire logic             clr,
   input  wire logic             pin,
   // Results
   output logic                  rise,
   output logic [CNT_W-1:0]      period,
   output logic                  valid,
   output logic                  sat
);
   typedef struct packed {
      logic             s1;
      logic             s2;
      logic             prev;
      logic             seen;
      logic             valid;
      logic             sat;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] period;
   } slgs_pm_s;

   slgs_pm_s r_reg, r_next;

   always_comb begin
      r_next      = r_reg;
      r_next.s1   = pin;
      r_next.s2   = r_reg.s1;
      r_next.prev = r_reg.s2;
      if (clr) begin
         r_next.cnt   = '0;
         r_next.seen  = 1'b0;
         r_next.valid = 1'b0;
         r_next.sat   = 1'b0;
      end else if (r_reg.s2 && !r_reg.prev) begin
         r_next.period = r_reg.cnt;
         r_next.valid  = r_reg.seen;
         r_next.seen   = 1'b1;
         r_next.cnt    = CNT_W'(1);
         r_next.sat    = 1'b0;
      end else if (r_reg.cnt != LIMIT) begin
         r_next.cnt = CNT_W'(r_reg.cnt + CNT_W'(1));
      end else begin
         // Counting stops at LIMIT so the flag stays put
         r_next.sat = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rise   = r_reg.s2 && !r_reg.prev && !clr;
   assign period = r_reg.period;
   assign valid  = r_reg.valid;
   assign sat    = r_reg.sat;
endmodule : slgs_period_meter
`default_nettype wire

// ==== src/slgs_pkg.sv ====
// Constants, types and register map of the speed-loop and gate-state block.
// Assumes one clock standing for the internal reference clock.
package slgs_pkg;
   // ---------------------------------------------------------------
   // Register map (APB byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_STATUS  = 8'h04;
   localparam logic [7:0] OFF_REFPER  = 8'h08;
   localparam logic [7:0] OFF_TACHPER = 8'h0c;
   localparam int         CTRL_LOCK_BIT = 0;
   localparam int         ST_MODE_LSB   = 0;
   localparam int         ST_SLOCK_BIT  = 5;
   localparam int         ST_FCMD_LSB   = 6;
   localparam int         ST_PCMD_LSB   = 8;
   localparam int         ST_GAIN_LSB   = 10;
   localparam int         ST_PULL_BIT   = 13;
   localparam logic       CTRL_LOCK_RST = 1'b0;
   // ---------------------------------------------------------------
   // Timing and counts
   // ---------------------------------------------------------------
   localparam int         CNT_W        = 16;
   localparam logic [15:0] OVF_COUNT   = 16'h8000;
   localparam logic [5:0] STBY_OFF_CYC = 6'h22;
   localparam logic [1:0] MIN_REF_EDGES = 2'h2;
   localparam logic [1:0] ACC_TACH_EDGES = 2'h2;
   localparam logic [15:0] GAIN_LIM [0:6] = '{16'h411b, 16'h3415,
      16'h2b67, 16'h2534, 16'h1ea3, 16'h1a0b, 16'h115d};
   // Pin synchroniser order: supply, regulator, pump, brake_n, start
   localparam logic [4:0] SYNC_RST = 5'h03;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      MD_RUN   = 5'h01,
      MD_BRAKE = 5'h02,
      MD_OVF   = 5'h04,
      MD_STOFF = 5'h08,
      MD_STBY  = 5'h10
   } slgs_mode_e;
   typedef enum logic [1:0] {
      CMD_IDLE  = 2'h0,
      CMD_ACCEL = 2'h1,
      CMD_SLOW  = 2'h2
   } slgs_cmd_e;
   typedef struct packed {
      logic src;
      logic snk;
   } slgs_gate_s;
   localparam slgs_gate_s GATE_HIGH = '{src: 1'b1, snk: 1'b0};
   localparam slgs_gate_s GATE_LOW  = '{src: 1'b0, snk: 1'b1};
   localparam slgs_gate_s GATE_OFF  = '{src: 1'b0, snk: 1'b0};
endpackage : slgs_pkg

// ==== src/slgs_speed_gate.sv ====
// Speed-loop and gate-state logic with an APB register slave.
// Assumes pclk stands for the internal reference clock and that the
// PWM pattern arrives from logic on the same clock.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module slgs_speed_gate #(
   parameter int N_PH = 3
) (
   // Clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // APB slave
   input  wire logic [7:0]                    paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic [31:0]                        prdata,
   output logic                               pready,
   output logic                               pslverr,
   // Pins, asynchronous
   input  wire logic                          start_pin,
   input  wire logic                          brake_n_pin,
   input  wire logic                          fref_pin,
   input  wire logic                          tach_feedback,
   input  wire logic                          pump_rail_uv,
   input  wire logic                          reg_rail_uv,
   input  wire logic                          supply_uv,
   // PWM pattern, same clock
   input  wire logic [N_PH-1:0]               pwm_upper,
   input  wire logic [N_PH-1:0]               pwm_lower,
   // Gate drive
   output slgs_pkg::slgs_gate_s [N_PH-1:0]    gate_upper,
   output slgs_pkg::slgs_gate_s [N_PH-1:0]    gate_lower,
   // Error commands and status
   output slgs_pkg::slgs_cmd_e                freq_cmd,
   output logic [2:0]                         freq_gain,
   output slgs_pkg::slgs_cmd_e                phase_cmd,
   output logic                               err_pulldown,
   output logic                               ref_clk_stop,
   output logic                               ovf_flag
);
   typedef struct packed {
      logic [4:0]                          s1;
      logic [4:0]                          s2;
      slgs_pkg::slgs_mode_e                mode;
      logic [5:0]                          tmr;
      logic [1:0]                          ref_left;
      logic [1:0]                          tach_left;
      slgs_pkg::slgs_cmd_e                 ph;
      logic                                lock_ctl;
      logic [31:0]                         rdata;
      logic                                slverr;
      slgs_pkg::slgs_gate_s [N_PH-1:0]     up;
      slgs_pkg::slgs_gate_s [N_PH-1:0]     lo;
      slgs_pkg::slgs_cmd_e                 fcmd;
      slgs_pkg::slgs_cmd_e                 pcmd;
      logic [2:0]                          gain;
      logic                                pull;
   } slgs_st_s;

   slgs_st_s r_reg, r_next;

   logic                       meter_clr;
   logic                       ref_rise, tach_rise;
   logic                       ref_valid, tach_valid;
   logic                       ref_sat;
   logic [slgs_pkg::CNT_W-1:0] ref_per, tach_per;
   logic                       start_lvl, brake_lvl;
   logic                       pump_uv, any_uv, speed_lock;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [2:0] gain_step(input logic [15:0] per);
      logic [2:0] g;
      g = 3'h0;
      for (int k = 0; k < 7; k++) begin
         if (per < slgs_pkg::GAIN_LIM[k]) begin
            g = 3'(k + 1);
         end
      end
      return g;
   endfunction : gain_step

   function automatic logic mapped(input logic [7:0] a);
      return a == slgs_pkg::OFF_CTRL || a == slgs_pkg::OFF_STATUS ||
             a == slgs_pkg::OFF_REFPER || a == slgs_pkg::OFF_TACHPER;
   endfunction : mapped

   // ---------------------------------------------------------------
   // Period meters
   // ---------------------------------------------------------------
   // Clock is stopped in standby, so nothing is counted outside run
   assign meter_clr = r_reg.mode != slgs_pkg::MD_RUN;

   slgs_period_meter u_ref (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (meter_clr),
      .pin     (fref_pin),
      .rise    (ref_rise),
      .period  (ref_per),
      .valid   (ref_valid),
      .sat     (ref_sat)
   );

   slgs_period_meter u_tach (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (meter_clr),
      .pin     (tach_feedback),
      .rise    (tach_rise),
      .period  (tach_per),
      .valid   (tach_valid),
      .sat     ()
   );

   assign start_lvl = r_reg.s2[0];
   assign brake_lvl = !r_reg.s2[1];
   assign pump_uv   = r_reg.s2[2];
   assign any_uv    = pump_uv || r_reg.s2[3] || r_reg.s2[4];
   // Locked inside one sixteenth of the reference period
   assign speed_lock = ref_valid && tach_valid &&
      ((tach_per > ref_per) ? (tach_per - ref_per) : (ref_per - tach_per))
      <= (ref_per >> 4);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [31:0] st_word;
      logic        settled;
      st_word = '0;
      settled = 1'b0;
      r_next  = r_reg;
      r_next.s1 = {supply_uv, reg_rail_uv, pump_rail_uv, brake_n_pin,
                   start_pin};
      r_next.s2 = r_reg.s1;

      if (start_lvl && r_reg.mode != slgs_pkg::MD_STBY &&
          r_reg.mode != slgs_pkg::MD_STOFF) begin
         r_next.mode = slgs_pkg::MD_STOFF;
         r_next.tmr  = '0;
      end else begin
         unique case (r_reg.mode)
            slgs_pkg::MD_STBY: begin
               if (!start_lvl) begin
                  r_next.mode      = slgs_pkg::MD_RUN;
                  r_next.ref_left  = slgs_pkg::MIN_REF_EDGES;
                  r_next.tach_left = slgs_pkg::ACC_TACH_EDGES;
               end
            end
            slgs_pkg::MD_STOFF: begin
               if (r_reg.tmr == slgs_pkg::STBY_OFF_CYC - 6'h1) begin
                  r_next.mode = slgs_pkg::MD_STBY;
               end else begin
                  r_next.tmr = 6'(r_reg.tmr + 6'h1);
               end
            end
            slgs_pkg::MD_RUN: begin
               if (brake_lvl) begin
                  r_next.mode = slgs_pkg::MD_BRAKE;
               end else if (ref_sat) begin
                  r_next.mode = slgs_pkg::MD_OVF;
               end
            end
            slgs_pkg::MD_BRAKE: begin
               if (!brake_lvl) begin
                  r_next.mode     = slgs_pkg::MD_RUN;
                  r_next.ref_left = slgs_pkg::MIN_REF_EDGES;
               end
            end
            slgs_pkg::MD_OVF: begin
               if (brake_lvl) begin
                  r_next.mode = slgs_pkg::MD_BRAKE;
               end
            end
         endcase
      end

      if (r_reg.mode == slgs_pkg::MD_RUN) begin
         if (ref_rise && r_reg.ref_left != 2'h0) begin
            r_next.ref_left = 2'(r_reg.ref_left - 2'h1);
         end
         if (tach_rise && r_reg.tach_left != 2'h0) begin
            r_next.tach_left = 2'(r_reg.tach_left - 2'h1);
         end
      end
      settled = r_reg.ref_left == 2'h0 && r_reg.tach_left == 2'h0;

      if (r_reg.mode != slgs_pkg::MD_RUN || !settled) begin
         r_next.ph = slgs_pkg::CMD_IDLE;
      end else if (ref_rise && tach_rise) begin
         r_next.ph = slgs_pkg::CMD_IDLE;
      end else if (ref_rise) begin
         r_next.ph = (r_reg.ph == slgs_pkg::CMD_SLOW) ?
                     slgs_pkg::CMD_IDLE : slgs_pkg::CMD_ACCEL;
      end else if (tach_rise) begin
         r_next.ph = (r_reg.ph == slgs_pkg::CMD_ACCEL) ?
                     slgs_pkg::CMD_IDLE : slgs_pkg::CMD_SLOW;
      end

      r_next.gain = 3'h0;
      r_next.pcmd = slgs_pkg::CMD_IDLE;
      if (r_reg.mode != slgs_pkg::MD_RUN) begin
         r_next.fcmd = slgs_pkg::CMD_IDLE;
      end else if (r_reg.ref_left != 2'h0) begin
         r_next.fcmd = slgs_pkg::CMD_ACCEL;
      end else begin
         r_next.gain = gain_step(ref_per);
         if (r_reg.tach_left != 2'h0 || !tach_valid ||
             tach_per > ref_per) begin
            r_next.fcmd = slgs_pkg::CMD_ACCEL;
         end else if (tach_per < ref_per) begin
            r_next.fcmd = slgs_pkg::CMD_SLOW;
         end else begin
            r_next.fcmd = slgs_pkg::CMD_IDLE;
         end
         if (speed_lock && settled) begin
            r_next.pcmd = r_reg.ph;
         end
      end
      r_next.pull = r_reg.mode == slgs_pkg::MD_STBY ||
                    r_reg.mode == slgs_pkg::MD_STOFF;

      for (int i = 0; i < N_PH; i++) begin
         if (any_uv) begin
            r_next.up[i] = slgs_pkg::GATE_LOW;
            r_next.lo[i] = slgs_pkg::GATE_LOW;
         end else if (r_reg.mode == slgs_pkg::MD_STBY) begin
            r_next.up[i] = slgs_pkg::GATE_OFF;
            r_next.lo[i] = slgs_pkg::GATE_LOW;
         end else if (r_reg.mode == slgs_pkg::MD_RUN && !r_reg.lock_ctl)
         begin
            r_next.up[i] = pwm_upper[i] ? slgs_pkg::GATE_HIGH :
                                          slgs_pkg::GATE_LOW;
            r_next.lo[i] = pwm_lower[i] ? slgs_pkg::GATE_HIGH :
                                          slgs_pkg::GATE_LOW;
         end else if (r_reg.mode == slgs_pkg::MD_BRAKE && !r_reg.lock_ctl)
         begin
            r_next.up[i] = slgs_pkg::GATE_LOW;
            r_next.lo[i] = slgs_pkg::GATE_HIGH;
         end else begin
            r_next.up[i] = slgs_pkg::GATE_LOW;
            r_next.lo[i] = slgs_pkg::GATE_LOW;
         end
      end

      // APB: data latched in setup so it stands through the access
      st_word[slgs_pkg::ST_MODE_LSB +: 5] = r_reg.mode;
      st_word[slgs_pkg::ST_SLOCK_BIT]     = speed_lock;
      st_word[slgs_pkg::ST_FCMD_LSB +: 2] = r_reg.fcmd;
      st_word[slgs_pkg::ST_PCMD_LSB +: 2] = r_reg.pcmd;
      st_word[slgs_pkg::ST_GAIN_LSB +: 3] = r_reg.gain;
      st_word[slgs_pkg::ST_PULL_BIT]      = r_reg.pull;
      if (psel && !penable) begin
         r_next.slverr = !mapped(paddr);
         r_next.rdata  = '0;
         if (!pwrite) begin
            unique case (paddr)
               slgs_pkg::OFF_CTRL:
                  r_next.rdata[slgs_pkg::CTRL_LOCK_BIT] = r_reg.lock_ctl;
               slgs_pkg::OFF_STATUS:  r_next.rdata = st_word;
               slgs_pkg::OFF_REFPER:  r_next.rdata = {16'h0, ref_per};
               slgs_pkg::OFF_TACHPER: r_next.rdata = {16'h0, tach_per};
               default:               r_next.rdata = '0;
            endcase
         end
      end
      if (psel && penable && pwrite && paddr == slgs_pkg::OFF_CTRL) begin
         r_next.lock_ctl = pwdata[slgs_pkg::CTRL_LOCK_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg          <= '0;
         r_reg.s1       <= slgs_pkg::SYNC_RST;
         r_reg.s2       <= slgs_pkg::SYNC_RST;
         r_reg.mode     <= slgs_pkg::MD_STBY;
         r_reg.lock_ctl <= slgs_pkg::CTRL_LOCK_RST;
         r_reg.up       <= {N_PH{slgs_pkg::GATE_OFF}};
         r_reg.lo       <= {N_PH{slgs_pkg::GATE_LOW}};
         r_reg.pull     <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata       = r_reg.rdata;
   assign pready       = 1'b1;
   assign pslverr      = r_reg.slverr;
   assign gate_upper   = r_reg.up;
   assign gate_lower   = r_reg.lo;
   assign freq_cmd     = r_reg.fcmd;
   assign freq_gain    = r_reg.gain;
   assign phase_cmd    = r_reg.pcmd;
   assign err_pulldown = r_reg.pull;
   // The low interval still needs clocks, so stop only once it is over
   assign ref_clk_stop = r_reg.mode == slgs_pkg::MD_STBY;
   assign ovf_flag     = r_reg.mode == slgs_pkg::MD_OVF;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic clash;
   assign clash = |{gate_upper, gate_lower} &&
      ((({gate_upper, gate_lower} >> 1) & {gate_upper, gate_lower} &
        {N_PH*2{2'h1}}) != '0);

   AST_GATE_TRI: assert property (!clash)
      else $error("gate source and sink both on");
   AST_BRAKE_DRV: assert property (
      r_reg.mode == slgs_pkg::MD_BRAKE && !any_uv && !r_reg.lock_ctl
      |=> gate_upper[0] == slgs_pkg::GATE_LOW &&
          gate_lower[0] == slgs_pkg::GATE_HIGH)
      else $error("brake gate state wrong");
   AST_STBY_DRV: assert property (
      r_reg.mode == slgs_pkg::MD_STBY && !any_uv
      |=> gate_upper[0] == slgs_pkg::GATE_OFF &&
          gate_lower[0] == slgs_pkg::GATE_LOW)
      else $error("standby gate state wrong");
   AST_UV_LOW: assert property (any_uv
      |=> gate_upper[0] == slgs_pkg::GATE_LOW &&
          gate_lower[0] == slgs_pkg::GATE_LOW)
      else $error("undervoltage gates not low");
   AST_STOFF_LEN: assert property (
      $rose(r_reg.mode == slgs_pkg::MD_STOFF)
      |-> ##33 r_reg.mode == slgs_pkg::MD_STOFF
          ##1 r_reg.mode == slgs_pkg::MD_STBY)
      else $error("standby low interval not 34 clocks");
   AST_START_STBY: assert property (
      start_lvl && r_reg.mode == slgs_pkg::MD_RUN
      |=> r_reg.mode == slgs_pkg::MD_STOFF ##1 !ref_clk_stop)
      else $error("start high did not enter standby");
   AST_FREQ_DIR: assert property (
      r_reg.mode == slgs_pkg::MD_RUN && !start_lvl && !brake_lvl &&
      r_reg.ref_left == 2'h0 && tach_valid && tach_per < ref_per &&
      r_reg.tach_left == 2'h0 |=> freq_cmd == slgs_pkg::CMD_SLOW)
      else $error("fast tach did not slow down");
   AST_PH_LOCK: assert property (!speed_lock
      |=> phase_cmd == slgs_pkg::CMD_IDLE)
      else $error("phase active while unlocked");
   AST_PULL: assert property (r_reg.mode == slgs_pkg::MD_STBY
      |=> err_pulldown && freq_cmd == slgs_pkg::CMD_IDLE)
      else $error("error outputs not pulled low");
   AST_OVF: assert property (
      r_reg.mode == slgs_pkg::MD_RUN && ref_sat && !start_lvl &&
      !brake_lvl |=> ovf_flag ##1 gate_upper[0] == slgs_pkg::GATE_LOW ||
      any_uv)
      else $error("overflow not flagged");
   AST_OVF_HOLD: assert property (
      ovf_flag && !start_lvl && !brake_lvl |=> ovf_flag)
      else $error("overflow left without clear");
   AST_MIN_AMP: assert property (
      r_reg.mode == slgs_pkg::MD_RUN && r_reg.ref_left != 2'h0
      |=> freq_cmd == slgs_pkg::CMD_ACCEL && freq_gain == 3'h0)
      else $error("minimum accelerate not held");
   AST_PH_LAG: assert property (
      r_reg.mode == slgs_pkg::MD_RUN && r_reg.ref_left == 2'h0 &&
      r_reg.tach_left == 2'h0 && ref_rise && !tach_rise &&
      r_reg.ph == slgs_pkg::CMD_IDLE |=> r_reg.ph == slgs_pkg::CMD_ACCEL)
      else $error("lagging tach did not accelerate");
   AST_PH_LEAD: assert property (
      r_reg.mode == slgs_pkg::MD_RUN && r_reg.ref_left == 2'h0 &&
      r_reg.tach_left == 2'h0 && tach_rise && !ref_rise &&
      r_reg.ph == slgs_pkg::CMD_IDLE |=> r_reg.ph == slgs_pkg::CMD_SLOW)
      else $error("leading tach did not slow down");

   COV_STBY: cover property ($rose(ref_clk_stop));
   COV_OVF: cover property ($rose(ovf_flag));
   COV_BRAKE_RUN: cover property (
      r_reg.mode == slgs_pkg::MD_BRAKE ##1 r_reg.mode == slgs_pkg::MD_RUN);
   COV_PH_SLOW: cover property (phase_cmd == slgs_pkg::CMD_SLOW);
endmodule : slgs_speed_gate
`default_nettype wire
